//--- erbf_map.vh
// Register map, field positions and reset values of the RAM/FIFO block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef ERBF_MAP_VH
`define ERBF_MAP_VH

// ------------------------------------------------------------
// Storage
// ------------------------------------------------------------
`define ERBF_BITS 13'd4608
`define ERBF_MAX_W 5'd18

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ERBF_OFS_CTRL 8'h00
`define ERBF_OFS_DEPTH 8'h04
`define ERBF_OFS_AE_THR 8'h08
`define ERBF_OFS_AF_THR 8'h0c
`define ERBF_OFS_STATUS 8'h10
`define ERBF_OFS_IRQ_STAT 8'h14
`define ERBF_OFS_IRQ_MASK 8'h18

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define ERBF_CTRL_FIFO 0
`define ERBF_CTRL_WCODE_LO 1
`define ERBF_CTRL_RCODE_LO 4
`define ERBF_CTRL_ROM 7

// ------------------------------------------------------------
// Width codes
// ------------------------------------------------------------
`define ERBF_W1 3'h0
`define ERBF_W2 3'h1
`define ERBF_W4 3'h2
`define ERBF_W9 3'h3
`define ERBF_W18 3'h4

// ------------------------------------------------------------
// Status and interrupt fields
// ------------------------------------------------------------
`define ERBF_ST_EMPTY 0
`define ERBF_ST_FULL 1
`define ERBF_ST_AE 2
`define ERBF_ST_AF 3
`define ERBF_ST_COUNT_LO 16
`define ERBF_IRQ_OVF 0
`define ERBF_IRQ_UDF 1
`define ERBF_IRQ_AF 2
`define ERBF_IRQ_AE 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ERBF_RST_CTRL 8'h48
`define ERBF_RST_DEPTH 13'h0100
`define ERBF_RST_AE_THR 13'h0004
`define ERBF_RST_AF_THR 13'h00fc
`define ERBF_RST_MASK 4'h0

`endif

//--- erbf_ptr.v
// Wrapping word pointer for one port of the FIFO controller.
// Assumes a synchronous clear and a limit of at least one word.
`timescale 1ns/1ps
module erbf_ptr (
   input wire sys_clk_in,
   input wire clear_in,
   input wire ce_in,
   input wire step_in,
   input wire [12:0] limit_in,
   output reg [11:0] ptr_out
);
   wire [12:0] ptr_ext;
   wire at_end;

   assign ptr_ext = {1'b0, ptr_out};
   assign at_end = (ptr_ext + 13'h0001) >= limit_in;

   always @(posedge sys_clk_in) begin
      if (clear_in) begin
         ptr_out <= 12'h000;
      end else if (ce_in && step_in) begin
         if (at_end) begin
            ptr_out <= 12'h000;
         end else begin
            ptr_out <= ptr_out + 12'h001;
         end
      end
   end
endmodule

//--- erbf_ram.v
// Bit-addressed 4608-bit array with independent write and read ports.
// Assumes base addresses already scaled by the port width.
`timescale 1ns/1ps
`include "erbf_map.vh"
module erbf_ram (
   input wire sys_clk_in,
   input wire ce_in,
   input wire we_in,
   input wire [12:0] wbase_in,
   input wire [4:0] wwidth_in,
   input wire [17:0] wdata_in,
   input wire re_in,
   input wire [12:0] rbase_in,
   input wire [4:0] rwidth_in,
   output reg [17:0] rdata_out
);
   reg mem [0:4607];
   integer b;

   // Word i of width w holds bits i*w upward, so any width reads in order
   always @(posedge sys_clk_in) begin
      if (ce_in) begin
         for (b = 0; b < 18; b = b + 1) begin
            if (we_in && (b < wwidth_in) && ({1'b0, wbase_in} + b < `ERBF_BITS)) begin
               mem[wbase_in + b] <= wdata_in[b];
            end
            if (re_in) begin
               if ((b < rwidth_in) && ({1'b0, rbase_in} + b < `ERBF_BITS)) begin
                  rdata_out[b] <= mem[rbase_in + b];
               end else begin
                  rdata_out[b] <= 1'b0;
               end
            end
         end
      end
   end
endmodule

//--- erbf_top.v
// Embedded RAM block with optional synchronous FIFO controller and APB registers.
// Assumes user logic on both ports and APB synchronous to sys_clk_in.
//
// Overview of operation
// - Storage is 4608 bits at x18 and x9, 4096 bits at x4, x2 and x1
// - Organizations 256x18, 512x9, 1kx4, 2kx2, 4kx1
// - Independent read and write ports, own widths outside FIFO mode
// - Mixed widths keep bit order across ports
// - Built-in FIFO control, no extra logic
// - FIFO width and depth are programmable
// - Empty, full, almost-empty, almost-full flags
// - Counters generate read and write pointers
// - Contents preloadable from test port, ROM mode
`timescale 1ns/1ps
`include "erbf_map.vh"
module erbf_top (
   input wire sys_clk_in,
   input wire reset_in,
   input wire ce_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output wire pready_out,
   output reg pslverr_out,
   input wire wr_en_in,
   input wire [11:0] wr_addr_in,
   input wire [17:0] wr_data_in,
   input wire rd_en_in,
   input wire [11:0] rd_addr_in,
   output wire [17:0] rd_data_out,
   output reg rd_valid_out,
   output wire full_out,
   output wire empty_out,
   output wire almost_full_flag_out,
   output wire almost_empty_flag_out,
   output wire irq_out,
   input wire tst_we_in,
   input wire [12:0] tst_addr_in,
   input wire tst_bit_in
);
   // ------------------------------------------------------------
   // Width helpers
   // ------------------------------------------------------------
   function [4:0] width_of;
      input [2:0] code;
      begin
         case (code)
            `ERBF_W1: width_of = 5'd1;
            `ERBF_W2: width_of = 5'd2;
            `ERBF_W4: width_of = 5'd4;
            `ERBF_W9: width_of = 5'd9;
            default: width_of = `ERBF_MAX_W;
         endcase
      end
   endfunction

   function [12:0] cap_of;
      input [2:0] code;
      begin
         case (code)
            `ERBF_W1: cap_of = 13'd4096;
            `ERBF_W2: cap_of = 13'd2048;
            `ERBF_W4: cap_of = 13'd1024;
            `ERBF_W9: cap_of = 13'd512;
            default: cap_of = 13'd256;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   localparam [7:0] RST_CTRL_WORD = `ERBF_RST_CTRL;
   reg fifo_mode;
   reg rom_mode;
   reg [2:0] wr_code;
   reg [2:0] rd_code;
   reg [12:0] depth;
   reg [12:0] ae_thr;
   reg [12:0] af_thr;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg [12:0] count;
   reg [12:0] next_count;
   reg af_prev;
   reg ae_prev;
   reg [31:0] next_rdata;
   reg next_slverr;

   wire setup_ph;
   wire apb_wr;
   wire flush;
   wire [4:0] w_width;
   wire [4:0] r_width;
   wire [12:0] w_cap;
   wire [12:0] r_cap;
   wire [12:0] eff_depth;
   wire full;
   wire empty;
   wire af;
   wire ae;
   wire wr_acc;
   wire rd_acc;
   wire [11:0] wptr;
   wire [11:0] rptr;
   wire [11:0] w_word;
   wire [11:0] r_word;
   wire [16:0] w_prod;
   wire [16:0] r_prod;
   wire ram_we;
   wire [12:0] ram_wbase;
   wire [4:0] ram_wwidth;
   wire [17:0] ram_wdata;
   wire [3:0] irq_event;
   wire [31:0] status_word;

   assign setup_ph = psel_in && !penable_in;
   assign pready_out = psel_in && penable_in && ce_in;
   assign apb_wr = pready_out && pwrite_in && !pslverr_out;
   assign flush = apb_wr && (paddr_in == `ERBF_OFS_CTRL);

   // ------------------------------------------------------------
   // Organization and depth
   // ------------------------------------------------------------
   assign w_width = width_of(wr_code);
   assign w_cap = cap_of(wr_code);
   // FIFO runs both ports at the write width
   assign r_width = fifo_mode ? w_width : width_of(rd_code);
   assign r_cap = fifo_mode ? w_cap : cap_of(rd_code);
   // Depth of zero or beyond capacity means the whole block
   assign eff_depth = ((depth == 13'h0000) || (depth > w_cap)) ? w_cap : depth;

   // ------------------------------------------------------------
   // FIFO flags
   // ------------------------------------------------------------
   assign full = fifo_mode && (count == eff_depth);
   assign empty = fifo_mode && (count == 13'h0000);
   assign af = fifo_mode && (count >= af_thr);
   assign ae = fifo_mode && (count <= ae_thr);
   assign full_out = full;
   assign empty_out = empty;
   assign almost_full_flag_out = af;
   assign almost_empty_flag_out = ae;

   // ------------------------------------------------------------
   // Port acceptance
   // ------------------------------------------------------------
   // Test-port load takes the write port for its cycle
   assign wr_acc = wr_en_in && !tst_we_in && !rom_mode && !(fifo_mode && full);
   assign rd_acc = rd_en_in && !(fifo_mode && empty);

   // ------------------------------------------------------------
   // Pointer counters
   // ------------------------------------------------------------
   erbf_ptr u_wptr (
      .sys_clk_in(sys_clk_in),
      .clear_in(reset_in || (ce_in && flush)),
      .ce_in(ce_in),
      .step_in(fifo_mode && wr_acc),
      .limit_in(eff_depth),
      .ptr_out(wptr)
   );

   erbf_ptr u_rptr (
      .sys_clk_in(sys_clk_in),
      .clear_in(reset_in || (ce_in && flush)),
      .ce_in(ce_in),
      .step_in(fifo_mode && rd_acc),
      .limit_in(eff_depth),
      .ptr_out(rptr)
   );

   // ------------------------------------------------------------
   // Address scaling
   // ------------------------------------------------------------
   // Capacities are powers of two, so masking wraps out-of-range words
   assign w_word = (fifo_mode ? wptr : wr_addr_in) & (w_cap[11:0] - 12'h001);
   assign r_word = (fifo_mode ? rptr : rd_addr_in) & (r_cap[11:0] - 12'h001);
   assign w_prod = w_word * w_width;
   assign r_prod = r_word * r_width;

   // Preload from the test port, one bit per cycle
   assign ram_we = wr_acc || tst_we_in;
   assign ram_wbase = tst_we_in ? tst_addr_in : w_prod[12:0];
   assign ram_wwidth = tst_we_in ? 5'd1 : w_width;
   assign ram_wdata = tst_we_in ? {17'h00000, tst_bit_in} : wr_data_in;

   erbf_ram u_ram (
      .sys_clk_in(sys_clk_in),
      .ce_in(ce_in),
      .we_in(ram_we),
      .wbase_in(ram_wbase),
      .wwidth_in(ram_wwidth),
      .wdata_in(ram_wdata),
      .re_in(rd_acc),
      .rbase_in(r_prod[12:0]),
      .rwidth_in(r_width),
      .rdata_out(rd_data_out)
   );

   // ------------------------------------------------------------
   // Fill count
   // ------------------------------------------------------------
   always @* begin
      next_count = count;
      if (fifo_mode) begin
         if (wr_acc && !rd_acc) begin
            next_count = count + 13'h0001;
         end else if (rd_acc && !wr_acc) begin
            next_count = count - 13'h0001;
         end
      end
   end

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         count <= 13'h0000;
         rd_valid_out <= 1'b0;
         af_prev <= 1'b0;
         ae_prev <= 1'b0;
      end else if (ce_in) begin
         count <= flush ? 13'h0000 : next_count;
         // Valid marks data that downstream blocks may chain into
         rd_valid_out <= rd_acc;
         af_prev <= af;
         ae_prev <= ae;
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   assign irq_event[`ERBF_IRQ_OVF] = fifo_mode && wr_en_in && full;
   assign irq_event[`ERBF_IRQ_UDF] = fifo_mode && rd_en_in && empty;
   assign irq_event[`ERBF_IRQ_AF] = af && !af_prev;
   assign irq_event[`ERBF_IRQ_AE] = ae && !ae_prev;
   assign irq_out = |(irq_stat & irq_mask);

   assign status_word = {3'h0, count, 12'h000,
                         af, ae, full, empty};

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   always @* begin
      next_rdata = 32'h00000000;
      next_slverr = 1'b0;
      if (paddr_in == `ERBF_OFS_CTRL) begin
         next_rdata = {24'h000000, rom_mode, rd_code, wr_code, fifo_mode};
      end else if (paddr_in == `ERBF_OFS_DEPTH) begin
         next_rdata = {19'h00000, depth};
      end else if (paddr_in == `ERBF_OFS_AE_THR) begin
         next_rdata = {19'h00000, ae_thr};
      end else if (paddr_in == `ERBF_OFS_AF_THR) begin
         next_rdata = {19'h00000, af_thr};
      end else if (paddr_in == `ERBF_OFS_STATUS) begin
         next_rdata = status_word;
      end else if (paddr_in == `ERBF_OFS_IRQ_STAT) begin
         next_rdata = {28'h0000000, irq_stat};
      end else if (paddr_in == `ERBF_OFS_IRQ_MASK) begin
         next_rdata = {28'h0000000, irq_mask};
      end else begin
         next_slverr = 1'b1;
      end
   end

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         prdata_out <= 32'h00000000;
         pslverr_out <= 1'b0;
      end else if (ce_in && setup_ph) begin
         prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
         pslverr_out <= next_slverr;
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         fifo_mode <= RST_CTRL_WORD[`ERBF_CTRL_FIFO];
         wr_code <= RST_CTRL_WORD[`ERBF_CTRL_WCODE_LO +: 3];
         rd_code <= RST_CTRL_WORD[`ERBF_CTRL_RCODE_LO +: 3];
         rom_mode <= RST_CTRL_WORD[`ERBF_CTRL_ROM];
         depth <= `ERBF_RST_DEPTH;
         ae_thr <= `ERBF_RST_AE_THR;
         af_thr <= `ERBF_RST_AF_THR;
         irq_mask <= `ERBF_RST_MASK;
         irq_stat <= 4'h0;
      end else if (ce_in) begin
         if (apb_wr && (paddr_in == `ERBF_OFS_CTRL)) begin
            fifo_mode <= pwdata_in[`ERBF_CTRL_FIFO];
            wr_code <= pwdata_in[`ERBF_CTRL_WCODE_LO +: 3];
            rd_code <= pwdata_in[`ERBF_CTRL_RCODE_LO +: 3];
            rom_mode <= pwdata_in[`ERBF_CTRL_ROM];
         end
         if (apb_wr && (paddr_in == `ERBF_OFS_DEPTH)) begin
            depth <= pwdata_in[12:0];
         end
         if (apb_wr && (paddr_in == `ERBF_OFS_AE_THR)) begin
            ae_thr <= pwdata_in[12:0];
         end
         if (apb_wr && (paddr_in == `ERBF_OFS_AF_THR)) begin
            af_thr <= pwdata_in[12:0];
         end
         if (apb_wr && (paddr_in == `ERBF_OFS_IRQ_MASK)) begin
            irq_mask <= pwdata_in[3:0];
         end
         // New events win over a same-cycle clear
         if (apb_wr && (paddr_in == `ERBF_OFS_IRQ_STAT)) begin
            irq_stat <= (irq_stat & ~pwdata_in[3:0]) | irq_event;
         end else begin
            irq_stat <= irq_stat | irq_event;
         end
      end
   end
endmodule

//--- erbf_user_model.sv
// User logic model on the data ports of the RAM/FIFO block.
// Assumes one caller at a time, tasks started from the bench.
`timescale 1ns/1ps
module erbf_user_model (
   input wire sys_clk_in,
   input wire [17:0] rd_data_in,
   input wire rd_valid_in,
   output reg wr_en_out,
   output reg [11:0] wr_addr_out,
   output reg [17:0] wr_data_out,
   output reg rd_en_out,
   output reg [11:0] rd_addr_out
);
   initial begin
      wr_en_out = 1'h0;
      wr_addr_out = 12'h000;
      wr_data_out = 18'h00000;
      rd_en_out = 1'h0;
      rd_addr_out = 12'h000;
   end
   // --------------------------------
   // Single-word transfers
   // --------------------------------
   task wr(input [11:0] a, input [17:0] dat);
      begin
         @(posedge sys_clk_in);
         wr_en_out <= 1'h1;
         wr_addr_out <= a;
         wr_data_out <= dat;
         @(posedge sys_clk_in);
         wr_en_out <= 1'h0;
         wr_data_out <= ~dat; // Stale data never looks valid
      end
   endtask
   task rd(input [11:0] a, output v, output [17:0] dat);
      begin
         @(posedge sys_clk_in);
         rd_en_out <= 1'h1;
         rd_addr_out <= a;
         @(posedge sys_clk_in);
         rd_en_out <= 1'h0;
         #1;
         v = rd_valid_in;
         dat = rd_data_in;
      end
   endtask
endmodule

//--- erbf_checker.sv
// Port-level checks of the FIFO flags and read handshake.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module erbf_checker (
   input wire sys_clk_in,
   input wire reset_in,
   input wire ce_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire wr_en_in,
   input wire rd_en_in,
   input wire rd_valid_out,
   input wire full_out,
   input wire empty_out,
   input wire almost_empty_flag_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   wire apb_wr = psel_in && penable_in && pwrite_in;
   // --------------------------------
   // Sequences
   // --------------------------------
   sequence s_rd_taken;
      ce_in && rd_en_in && !empty_out;
   endsequence
   sequence s_full_idle;
      full_out && ce_in && !rd_en_in && !apb_wr;
   endsequence
   sequence s_empty_idle;
      empty_out && ce_in && !wr_en_in && !apb_wr;
   endsequence
   // --------------------------------
   // Assertions
   // --------------------------------
   AST_FULL_HOLD: assert property (s_full_idle |=> full_out)
      else $error("full flag dropped without a read");
   AST_EMPTY_HOLD: assert property (s_empty_idle |=> empty_out)
      else $error("empty flag dropped without a write");
   AST_EMPTY_NO_VALID: assert property (
      empty_out && ce_in && rd_en_in |=> !rd_valid_out)
      else $error("read when empty gave data");
   AST_AE_WHEN_EMPTY: assert property (empty_out |-> almost_empty_flag_out)
      else $error("almost empty low while empty");
   AST_NOT_BOTH: assert property (!(full_out && empty_out))
      else $error("full and empty together");
   AST_RD_TO_VALID: assert property (s_rd_taken |=> rd_valid_out)
      else $error("accepted read gave no data");
   AST_VALID_CAUSE: assert property (
      rd_valid_out && $past(ce_in) |-> $past(rd_en_in))
      else $error("read data without a read");
   AST_CE_FREEZE: assert property (
      !ce_in |=> $stable(full_out) && $stable(empty_out) && $stable(rd_valid_out))
      else $error("state moved while disabled");
endmodule
bind erbf_top erbf_checker i_chk (.sys_clk_in, .reset_in, .ce_in, .psel_in, .penable_in,
   .pwrite_in, .wr_en_in, .rd_en_in, .rd_valid_out, .full_out, .empty_out,
   .almost_empty_flag_out);

//--- embedded_ram_block_with_fifo_tb.sv
// Bench for the RAM/FIFO block: registers, widths, preload and FIFO flags.
// Assumes the user model on the data ports and the bound checker.
`timescale 1ns/1ps
`include "erbf_map.vh"
module embedded_ram_block_with_fifo_tb;
   reg sys_clk_in = 1'h0;
   reg reset_in = 1'h1;
   reg ce_in = 1'h1;
   reg psel_in = 1'h0;
   reg penable_in = 1'h0;
   reg pwrite_in = 1'h0;
   reg [7:0] paddr_in = 8'h00;
   reg [31:0] pwdata_in = 32'h0;
   reg tst_we_in = 1'h0;
   reg [12:0] tst_addr_in = 13'h0;
   reg tst_bit_in = 1'h0;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out, wr_en_in, rd_en_in, rd_valid_out, irq_out;
   wire full_out, empty_out, almost_full_flag_out, almost_empty_flag_out;
   wire [11:0] wr_addr_in, rd_addr_in;
   wire [17:0] wr_data_in, rd_data_out;
   integer failures = 0;
   integer check_count = 0;
   reg [31:0] rdat;
   reg rerr;
   reg v;
   reg [17:0] d;
   always #25 sys_clk_in = ~sys_clk_in;
   erbf_top i_dut (.sys_clk_in, .reset_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .wr_en_in,
      .wr_addr_in, .wr_data_in, .rd_en_in, .rd_addr_in, .rd_data_out, .rd_valid_out,
      .full_out, .empty_out, .almost_full_flag_out, .almost_empty_flag_out, .irq_out,
      .tst_we_in, .tst_addr_in, .tst_bit_in);
   erbf_user_model i_usr (.sys_clk_in, .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out),
      .wr_en_out(wr_en_in), .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in),
      .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in));
   // --------------------------------
   // Shared tasks
   // --------------------------------
   task chk(input string n, input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0s exp %h got %h", n, exp, got);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] wd);
      begin
         @(posedge sys_clk_in);
         psel_in <= 1'h1;
         pwrite_in <= w;
         paddr_in <= a;
         pwdata_in <= wd;
         @(posedge sys_clk_in);
         penable_in <= 1'h1;
         @(posedge sys_clk_in);
         // Only the watchdog ends a wait for pready
         while (pready_out !== 1'h1) begin
            @(posedge sys_clk_in);
         end
         rdat = prdata_out;
         rerr = pslverr_out;
         psel_in <= 1'h0;
         penable_in <= 1'h0;
      end
   endtask
   task rdreg(input [7:0] a, input [31:0] exp);
      begin
         apb(1'h0, a, 32'h0);
         chk("reg", rdat, exp);
      end
   endtask
   function [4:0] wtab(input integer c);
      wtab = (c == 0) ? 5'h01 : (c == 1) ? 5'h02 : (c == 2) ? 5'h04 : (c == 3) ? 5'h09 : 5'h12;
   endfunction
   task end_of_test;
      begin
         $display("checks %0d failures %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // --------------------------------
   // Scenarios
   // --------------------------------
   task t_reset;
      begin
         rdreg(`ERBF_OFS_CTRL, {24'h0, `ERBF_RST_CTRL});
         rdreg(`ERBF_OFS_DEPTH, {19'h0, `ERBF_RST_DEPTH});
         rdreg(`ERBF_OFS_AE_THR, {19'h0, `ERBF_RST_AE_THR});
         rdreg(`ERBF_OFS_AF_THR, {19'h0, `ERBF_RST_AF_THR});
         rdreg(`ERBF_OFS_IRQ_MASK, {28'h0, `ERBF_RST_MASK});
         rdreg(8'h1c, 32'h0);
         chk("slverr", rerr, 1'h1);
      end
   endtask
   task t_widths;
      integer c;
      reg [17:0] m;
      begin
         for (c = 0; c < 5; c = c + 1) begin
            m = (18'h00001 << wtab(c)) - 18'h00001;
            apb(1'h1, `ERBF_OFS_CTRL, (c << 4) | (c << 1));
            i_usr.wr(12'h007, 18'h2a5b5);
            i_usr.rd(12'h007, v, d);
            chk("width", {13'h0, v, d}, {13'h0, 1'h1, 18'h2a5b5 & m});
         end
      end
   endtask
   task t_mixed;
      integer i;
      begin
         apb(1'h1, `ERBF_OFS_CTRL, 32'h00000004);
         i_usr.wr(12'h001, 18'h00009);
         for (i = 0; i < 4; i = i + 1) begin
            i_usr.rd(12'h004 + i[11:0], v, d);
            chk("mixed", {13'h0, v, d}, 32'h00040000 | ((32'h9 >> i) & 32'h1));
         end
      end
   endtask
   task t_rom;
      integer b;
      begin
         apb(1'h1, `ERBF_OFS_CTRL, 32'h000000b6);
         for (b = 0; b < 9; b = b + 1) begin
            @(posedge sys_clk_in);
            tst_we_in <= 1'h1;
            tst_addr_in <= 13'h11f7 + b[12:0];
            tst_bit_in <= ~b[0];
         end
         @(posedge sys_clk_in);
         tst_we_in <= 1'h0;
         i_usr.wr(12'h1ff, 18'h00000);
         i_usr.rd(12'h1ff, v, d);
         chk("rom", {13'h0, v, d}, 32'h00040155);
      end
   endtask
   task t_fifo;
      integer k;
      begin
         apb(1'h1, `ERBF_OFS_CTRL, 32'h00000037);
         apb(1'h1, `ERBF_OFS_DEPTH, 32'h00000008);
         apb(1'h1, `ERBF_OFS_AE_THR, 32'h00000002);
         apb(1'h1, `ERBF_OFS_AF_THR, 32'h00000006);
         apb(1'h1, `ERBF_OFS_IRQ_MASK, 32'h00000001);
         rdreg(`ERBF_OFS_STATUS, 32'h00000005);
         for (k = 0; k < 9; k = k + 1)
            i_usr.wr(12'h000, 18'h00011 * k);
         #1;
         chk("full", {full_out, almost_full_flag_out, irq_out}, 3'h7);
         rdreg(`ERBF_OFS_STATUS, 32'h0008000a);
         rdreg(`ERBF_OFS_IRQ_STAT, 32'h0000000d);
         apb(1'h1, `ERBF_OFS_IRQ_STAT, 32'h00000001);
         #1;
         chk("irq", irq_out, 1'h0);
         for (k = 0; k < 8; k = k + 1) begin
            i_usr.rd(12'h000, v, d);
            chk("pop", {13'h0, v, d}, 32'h00040000 | (32'h11 * k));
            chk("flags", {empty_out, almost_empty_flag_out, almost_full_flag_out},
               {k == 7, k >= 5, k <= 1});
         end
         i_usr.rd(12'h000, v, d);
         chk("underflow", v, 1'h0);
         rdreg(`ERBF_OFS_IRQ_STAT, 32'h0000000e);
         chk("masked", irq_out, 1'h0);
         @(posedge sys_clk_in);
         ce_in <= 1'h0;
         i_usr.wr(12'h000, 18'h00001);
         @(posedge sys_clk_in);
         ce_in <= 1'h1;
         #1;
         chk("frozen", empty_out, 1'h1);
      end
   endtask
   // --------------------------------
   // Main sequence and watchdog
   // --------------------------------
   initial begin
      repeat (10) @(posedge sys_clk_in);
      reset_in <= 1'h0;
      t_reset;
      t_widths;
      t_mixed;
      t_rom;
      t_fifo;
      end_of_test;
   end
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      failures = failures + 1;
      end_of_test;
   end
endmodule
